// ---- rtl/ppk_consts.svh ----
// Register offsets, reset values and field positions of the port block
`ifndef PPK_CONSTS_SVH
`define PPK_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPK_OFS_DATA0   8'h00
`define PPK_OFS_DIR0    8'h20
`define PPK_OFS_PUL     8'h30
`define PPK_OFS_PUH     8'h31
`define PPK_OFS_KRM     8'h32
`define PPK_OFS_KFLAG   8'h33
`define PPK_OFS_ALT     8'h34
`define PPK_OFS_ANA     8'h35
`define PPK_OFS_BITOP   8'h36

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define PPK_DIR_RST     8'hff
`define PPK_PU_RST      8'h00
`define PPK_KRM_RST     8'h02
`define PPK_PUH_MASK    8'h0f
`define PPK_PUL_MASK    8'h8f
`define PPK_KRM_RELEN   0
`define PPK_KRM_EDGESEL 1
`define PPK_P0_NOPU     8'h81

`endif

// ---- rtl/ppk_edge_det.sv ----
// Falling-edge detector for the key-return port
`timescale 1ns/10ps
module ppk_edge_det
  import ppk_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] level,
  output logic            fall
);

  logic [7:0] prev_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_q <= 8'hff;
    end else begin
      prev_q <= level;
    end
  end

  // High in one sample, low in the next
  assign fall = |(prev_q & ~level);

endmodule : ppk_edge_det

// ---- rtl/ppk_pkg.sv ----
// Types shared by the port block
package ppk_pkg;

  typedef logic [7:0] ppk_byte_t;

  typedef enum logic [2:0] {
    PPK_OP_AND = 3'b001,
    PPK_OP_OR  = 3'b010,
    PPK_OP_XOR = 3'b100
  } ppk_alu_e;

endpackage : ppk_pkg

// ---- rtl/ppk_port_ctrl.sv ----
// Port control: direction, pull-ups, latches and key-return detection
`timescale 1ns/10ps
`include "ppk_consts.svh"

// Operation
// - Direction bit 0 enables the output buffer, 1 disables it; port 0 bits 0 and 7 are never enabled.
// - Pull-up only when port option selected and pin is input.
// - Output pins and analog inputs never get the pull-up.
// - Reset clears both pull-up option registers to 00H.
// - Port 0 bits 0 and 7 never have a pull-up.
// - Ports 1, 8, 9 in alternate function get no pull-up.
// - Option and key-return registers take bit and byte writes.
// - Key-return mode enables standby release and selects edge input.
// - Reset loads key-return mode register with 02H.
// - Hardware never clears key-return flag; software must.
// - Output-mode write loads latch, drives pin, holds until next write.
// - Input-mode write updates latch but pin stays undriven.
// - Single-bit port operation is done as a full byte access.
// - Reading an output pin returns latch, latch unchanged.
// - Reading an input pin returns pin level, latch unchanged.
// - Output-mode logic op works on latch, stores back, drives pin.
// - Input-mode logic op leaves latch undefined, pin unaffected.
// - Reset sets every direction register to FFH.
// - Falling edge on port 11 sets the key-return flag.
module ppk_port_ctrl
  import ppk_pkg::*;
#(
  parameter int NPORT = 12
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  input  wire logic             regBitOp,
  input  wire logic [2:0]       regBitSel,
  input  wire logic [2:0]       regAluOp,
  output logic      [7:0]       regRdata,
  input  wire logic [8*NPORT-1:0] pinIn,
  output logic      [8*NPORT-1:0] pinOut,
  output logic      [8*NPORT-1:0] pinOe,
  output logic      [8*NPORT-1:0] pinPullup,
  output logic                  standbyRelease
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ppk_byte_t latch_q [NPORT];
  ppk_byte_t latch_d [NPORT];
  ppk_byte_t dir_q   [NPORT];
  ppk_byte_t dir_d   [NPORT];
  ppk_byte_t puL_q, puL_d, puH_q, puH_d;
  ppk_byte_t krm_q, krm_d, alt_q, alt_d, ana_q, ana_d;
  ppk_byte_t rdata_q, rdata_d;
  logic      kflag_q, kflag_d;
  logic      [8*NPORT-1:0] pinSync;
  logic      keyFall;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A bit operation merges one bit into the old byte; a byte write
  // replaces all of it
  function automatic ppk_byte_t merge(input ppk_byte_t old,
                                      input ppk_byte_t wd,
                                      input logic bitOp,
                                      input logic [2:0] sel);
    ppk_byte_t r;
    r = old;
    if (bitOp) begin
      r[sel] = wd[sel];
    end else begin
      r = wd;
    end
    return r;
  endfunction : merge

  function automatic ppk_byte_t aluRun(input ppk_byte_t a,
                                       input ppk_byte_t b,
                                       input logic [2:0] op);
    ppk_byte_t r;
    r = b;
    case (op)
      PPK_OP_AND: r = a & b;
      PPK_OP_OR:  r = a | b;
      PPK_OP_XOR: r = a ^ b;
      default:    r = b;
    endcase
    return r;
  endfunction : aluRun

  // Byte seen by a port read: latch for outputs, pin for inputs
  function automatic ppk_byte_t portView(input ppk_byte_t lat,
                                         input ppk_byte_t dir,
                                         input ppk_byte_t pin);
    return (lat & ~dir) | (pin & dir);
  endfunction : portView

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  ppk_sync3 #(.W(8*NPORT)) uSync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  ppk_edge_det uEdge (
    .mclk  (mclk),
    .rst   (rst),
    .level (pinSync[8*11 +: 8]),
    .fall  (keyFall)
  );

  // ----------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------
  always_comb begin
    ppk_byte_t view;
    view    = 8'h00;
    latch_d = latch_q;
    dir_d   = dir_q;
    puL_d   = puL_q;
    puH_d   = puH_q;
    krm_d   = krm_q;
    alt_d   = alt_q;
    ana_d   = ana_q;
    kflag_d = kflag_q;
    rdata_d = 8'h00;
    for (int p = 0; p < NPORT; p++) begin
      view = portView(latch_q[p], dir_q[p], pinSync[8*p +: 8]);
      if (regWrite && regAddr == `PPK_OFS_DATA0 + 8'(p)) begin
        // Whole byte rewritten even for one bit; input bits take
        // the pin level, which is the undefined case
        if (regAluOp != 3'b000) begin
          latch_d[p] = aluRun(view, regWdata, regAluOp);
        end else begin
          latch_d[p] = merge(view, regWdata, regBitOp,
                             regBitSel);
        end
      end else if (regWrite && regAddr == `PPK_OFS_DIR0 + 8'(p)) begin
        dir_d[p] = merge(dir_q[p], regWdata, regBitOp, regBitSel);
      end
      if (regRead && regAddr == `PPK_OFS_DATA0 + 8'(p)) begin
        rdata_d = view;
      end else if (regRead && regAddr == `PPK_OFS_DIR0 + 8'(p)) begin
        rdata_d = dir_q[p];
      end
    end
    if (regWrite) begin
      if (regAddr == `PPK_OFS_PUL) begin
        puL_d = merge(puL_q, regWdata, regBitOp, regBitSel);
      end else if (regAddr == `PPK_OFS_PUH) begin
        puH_d = merge(puH_q, regWdata, regBitOp, regBitSel);
      end else if (regAddr == `PPK_OFS_KRM) begin
        krm_d = merge(krm_q, regWdata, regBitOp, regBitSel);
      end else if (regAddr == `PPK_OFS_KFLAG) begin
        // Software clear; a byte write of 1 sets it too
        kflag_d = merge({7'h00, kflag_q}, regWdata, regBitOp,
                        regBitSel) == 8'h01;
      end else if (regAddr == `PPK_OFS_ALT) begin
        alt_d = regWdata;
      end else if (regAddr == `PPK_OFS_ANA) begin
        ana_d = regWdata;
      end
    end
    // Edge wins over a clear in the same cycle
    if (keyFall && krm_q[`PPK_KRM_EDGESEL]) begin
      kflag_d = 1'b1;
    end
    if (regRead) begin
      if (regAddr == `PPK_OFS_PUL) begin
        rdata_d = puL_q;
      end else if (regAddr == `PPK_OFS_PUH) begin
        rdata_d = puH_q;
      end else if (regAddr == `PPK_OFS_KRM) begin
        rdata_d = krm_q;
      end else if (regAddr == `PPK_OFS_KFLAG) begin
        rdata_d = {7'h00, kflag_q};
      end else if (regAddr == `PPK_OFS_ALT) begin
        rdata_d = alt_q;
      end else if (regAddr == `PPK_OFS_ANA) begin
        rdata_d = ana_q;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NPORT; p++) begin
        latch_q[p] <= 8'h00;
        dir_q[p]   <= `PPK_DIR_RST;
      end
      puL_q   <= `PPK_PU_RST;
      puH_q   <= `PPK_PU_RST;
      krm_q   <= `PPK_KRM_RST;
      alt_q   <= 8'h00;
      ana_q   <= 8'h00;
      kflag_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
      puL_q   <= puL_d;
      puH_q   <= puH_d;
      krm_q   <= krm_d;
      alt_q   <= alt_d;
      ana_q   <= ana_d;
      kflag_q <= kflag_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  // ----------------------------------------------------------------
  // Pin drive and pull-ups
  // ----------------------------------------------------------------
  // Option bit per port index: low register for 0..3 and 7,
  // high register for 8..11; reserved bits are ignored
  function automatic logic puSel(input int p, input ppk_byte_t lo,
                                 input ppk_byte_t hi);
    logic r;
    r = 1'b0;
    if (p < 4 || p == 7) begin
      r = lo[p[2:0]];
    end else if (p >= 8 && p < 12) begin
      r = hi[p[2:0]];
    end
    return r;
  endfunction : puSel

  always_comb begin
    ppk_byte_t bar;
    bar       = 8'h00;
    pinOut    = '0;
    pinOe     = '0;
    pinPullup = '0;
    for (int p = 0; p < NPORT; p++) begin
      pinOut[8*p +: 8] = latch_q[p];
      pinOe[8*p +: 8]  = ~dir_q[p];
      bar = 8'h00;
      if (p == 0) begin
        bar = `PPK_P0_NOPU;
        pinOe[7:0] = ~dir_q[0] & ~`PPK_P0_NOPU;
      end
      if (p == 1) begin
        bar = bar | ana_q;
      end
      if ((p == 1 || p == 8 || p == 9) && alt_q[p[2:0] & 3'd7]) begin
        bar = 8'hff;
      end
      if (puSel(p, puL_q, puH_q)) begin
        pinPullup[8*p +: 8] = dir_q[p] & ~bar;
      end
    end
  end

  assign standbyRelease = kflag_q & krm_q[`PPK_KRM_RELEN];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sFall;
    keyFall && krm_q[`PPK_KRM_EDGESEL];
  endsequence

  a_flag_sets: assert property (sFall |=> kflag_q)
    else $error("key flag not set after edge");
  a_flag_sticky: assert property (
    kflag_q && !(regWrite && regAddr == `PPK_OFS_KFLAG) |=> kflag_q)
    else $error("key flag cleared by hardware");
  a_oe_dir: assert property (pinOe[15:8] == ~dir_q[1])
    else $error("output enable disagrees with direction");
  a_pu_outpin: assert property ((pinOe & pinPullup) == '0)
    else $error("pull-up on output pin");
  a_p0_nopu: assert property ((pinPullup[7:0] & `PPK_P0_NOPU) == 8'h00)
    else $error("pull-up on input-only pin");
  a_alt_nopu: assert property (alt_q[1] |-> pinPullup[15:8] == 8'h00)
    else $error("pull-up on alternate pin");
  a_latch_hold: assert property (
    !regWrite |=> latch_q[2] == $past(latch_q[2]))
    else $error("latch changed without write");
  a_read_view: assert property (
    regRead && regAddr == `PPK_OFS_DATA0 + 8'd3 |=>
    regRdata == (($past(latch_q[3]) & ~$past(dir_q[3]))
                 | ($past(pinSync[31:24]) & $past(dir_q[3]))))
    else $error("port read value wrong");
  a_krm_write: assert property (
    regWrite && !regBitOp && regAddr == `PPK_OFS_KRM |=>
    krm_q == $past(regWdata))
    else $error("mode register write lost");

endmodule : ppk_port_ctrl

// ---- rtl/ppk_sync3.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ppk_sync3
  import ppk_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // Accept a bit only once stages two and three agree
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      out_q <= '1;
    end else begin
      s1_q  <= asyncIn;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;

endmodule : ppk_sync3

// ---- testbench/ppk_board_model.sv ----
// Board-side model of the port pins
`timescale 1ns/10ps
module ppk_board_model (
  input  wire logic        mclk,
  input  wire logic [95:0] pinOut,
  input  wire logic [95:0] pinOe,
  input  wire logic [95:0] pinPullup,
  input  wire logic [95:0] extEn,
  input  wire logic [95:0] extVal,
  output logic      [95:0] pinLevel
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  logic [95:0] lastQ = 96'h0;

  // A floating pin flips every cycle, so the synchroniser never accepts it and keeps reporting the last agreed value
  always_comb begin
    for (int i = 0; i < 96; i++) begin
      if (pinOe[i]) begin
        pinLevel[i] = pinOut[i];
      end else if (extEn[i]) begin
        pinLevel[i] = extVal[i];
      end else if (pinPullup[i]) begin
        pinLevel[i] = 1'b1;
      end else begin
        pinLevel[i] = ~lastQ[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    lastQ <= pinLevel;
  end
endmodule : ppk_board_model

// ---- testbench/ppk_port_ctrl_tb.sv ----
// Self-checking bench for the port control block
`timescale 1ns/10ps
module ppk_port_ctrl_tb
  import ppk_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk;
  logic        rst;
  logic [7:0]  regAddr;
  logic [7:0]  regWdata;
  logic        regWrite;
  logic        regRead;
  logic        regBitOp;
  logic [2:0]  regBitSel;
  logic [2:0]  regAluOp;
  logic [7:0]  regRdata;
  logic [95:0] pinLevel;
  logic [95:0] pinOut;
  logic [95:0] pinOe;
  logic [95:0] pinPullup;
  logic        standbyRelease;
  logic [95:0] extEn;
  logic [95:0] extVal;
  int          fails = 0;
  int          tests_run = 0;

  ppk_port_ctrl #(.NPORT(12)) dut_u (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regBitOp(regBitOp),
    .regBitSel(regBitSel), .regAluOp(regAluOp), .regRdata(regRdata),
    .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullup(pinPullup), .standbyRelease(standbyRelease));

  ppk_board_model board_u (
    .mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
    .extEn(extEn), .extVal(extVal), .pinLevel(pinLevel));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic ppk_byte_t sl(input logic [95:0] v, input int p);
    return v[8*p +: 8];
  endfunction : sl

  task automatic chk(input string what, input ppk_byte_t exp,
                     input ppk_byte_t got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input ppk_byte_t a, input ppk_byte_t d,
                    input logic [2:0] op = 3'h0, input logic bo = 1'b0,
                    input logic [2:0] sel = 3'h0);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regAluOp <= op;
    regBitOp <= bo;
    regBitSel <= sel;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAluOp <= 3'h0;
    regBitOp <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input string what, input ppk_byte_t a,
                    input ppk_byte_t exp);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(what, exp, regRdata);
  endtask : rd

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    rst <= 1'b1;
    regAddr <= 8'h00;
    regWdata <= 8'h00;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regBitOp <= 1'b0;
    regBitSel <= 3'h0;
    regAluOp <= 3'h0;
    extEn <= 96'h0;
    extVal <= 96'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd("dir3", 8'h23, 8'hff);
    rd("puLow", 8'h30, 8'h00);
    rd("puHigh", 8'h31, 8'h00);
    rd("keyMode", 8'h32, 8'h02);
    rd("unmapped", 8'h36, 8'h00);
    chk("oeReset", 8'h00, sl(pinOe, 3));
    $display("test reset done");
    wr(8'h23, 8'h00);
    chk("oeOut", 8'hff, sl(pinOe, 3));
    wr(8'h03, 8'ha5);
    chk("pinDriven", 8'ha5, sl(pinLevel, 3));
    rd("readOut", 8'h03, 8'ha5);
    chk("latchKept", 8'ha5, sl(pinOut, 3));
    wr(8'h03, 8'h0f, PPK_OP_AND);
    chk("andOp", 8'h05, sl(pinOut, 3));
    wr(8'h03, 8'hf0, PPK_OP_OR);
    chk("orOp", 8'hf5, sl(pinLevel, 3));
    wr(8'h03, 8'hff, PPK_OP_XOR);
    rd("xorOp", 8'h03, 8'h0a);
    $display("test output mode done");
    extEn[31:24] <= 8'hff;
    extVal[31:24] <= 8'h3c;
    wr(8'h23, 8'hff);
    wr(8'h03, 8'h5a);
    chk("latchIn", 8'h5a, sl(pinOut, 3));
    chk("oeIn", 8'h00, sl(pinOe, 3));
    repeat (5) @(posedge mclk);
    rd("readIn", 8'h03, 8'h3c);
    chk("latchIn2", 8'h5a, sl(pinOut, 3));
    wr(8'h03, 8'h00, PPK_OP_AND);
    chk("pinIn", 8'h3c, sl(pinLevel, 3));
    wr(8'h23, 8'h0f);
    wr(8'h03, 8'h00);
    wr(8'h03, 8'hff, 3'h0, 1'b1, 3'h1);
    chk("bitOp", 8'h0e, sl(pinOut, 3) & 8'h0f);
    $display("test input mode done");
    extEn <= 96'h0;
    wr(8'h30, 8'h08);
    chk("puMixed", 8'h0f, sl(pinPullup, 3));
    wr(8'h23, 8'hff);
    chk("puIn", 8'hff, sl(pinPullup, 3));
    wr(8'h30, 8'h8b);
    chk("puP0", 8'h7e, sl(pinPullup, 0));
    chk("puP1", 8'hff, sl(pinPullup, 1));
    wr(8'h35, 8'h0f);
    chk("puAnalog", 8'hf0, sl(pinPullup, 1));
    wr(8'h34, 8'h02);
    chk("puAlt", 8'h00, sl(pinPullup, 1));
    wr(8'h31, 8'h08);
    chk("puP11", 8'hff, sl(pinPullup, 11));
    chk("puP10", 8'h00, sl(pinPullup, 10));
    wr(8'h30, 8'hff, 3'h0, 1'b1, 3'h2);
    rd("bitSet", 8'h30, 8'h8f);
    wr(8'h30, 8'h00, 3'h0, 1'b1, 3'h7);
    rd("bitClr", 8'h30, 8'h0f);
    wr(8'h32, 8'hff, 3'h0, 1'b1, 3'h0);
    rd("modeBit", 8'h32, 8'h03);
    $display("test pull-up done");
    extEn[95:88] <= 8'hff;
    extVal[95:88] <= 8'hff;
    repeat (8) @(posedge mclk);
    rd("flagIdle", 8'h33, 8'h00);
    extVal[88] <= 1'b0;
    for (int i = 0; i < 12 && standbyRelease !== 1'b1; i++) begin
      @(posedge mclk);
    end
    #1;
    chk("release", 8'h01, {7'h0, standbyRelease});
    repeat (20) @(posedge mclk);
    rd("flagHeld", 8'h33, 8'h01);
    wr(8'h32, 8'h02);
    chk("relOff", 8'h00, {7'h0, standbyRelease});
    wr(8'h33, 8'h00);
    rd("flagClr", 8'h33, 8'h00);
    wr(8'h32, 8'h00);
    extVal[88] <= 1'b1;
    repeat (8) @(posedge mclk);
    extVal[88] <= 1'b0;
    repeat (10) @(posedge mclk);
    rd("edgeOff", 8'h33, 8'h00);
    $display("test key return done");
    print_verdict();
  end
endmodule : ppk_port_ctrl_tb
